// ==== ifs_pkg.sv ====
// Constants and types for the instruction fetch stage sequencer.
// Behaviour
// RULE_01 - End of alpha: latch holds the low six counter digits, leading zeros included.
// RULE_02 - Entering beta: one minor cycle of hold-off suppresses all transfers.
// RULE_03 - Each beta cycle: compare slot counter with latch rightmost digit; flag on equality.
// RULE_04 - Latch digits pick one of 100 channels; gate opens on select and match.
// RULE_05 - Beta waits for the match cycle, up to the tenth minor cycle.
// RULE_06 - Match cycle: memory word goes over the bus into the holder, parity checked.
// RULE_07 - Match cycle: address counter gets one added in its lowest digit.
// RULE_08 - End of match: step to gamma, set hold-off, close gates, open clear paths.
// RULE_09 - Counter input stays open briefly after hold-off so the whole sum lands.
// RULE_10 - Fetched word recirculates in holder; ending pulse loads left instruction into latch.
// RULE_11 - Six-digit instructions, two per word, both run from one memory access.
// RULE_12 - During gamma hold-off the latch drives decode; execution starts after hold-off.
// RULE_13 - Gamma end: load right instruction, step to delta, set hold-off together.
// RULE_14 - Delta repeats hold-off then execute; its end returns the stage to alpha.
// RULE_15 - Stage counter is two bits: alpha 00, beta 01, gamma 10, delta 11.
// RULE_16 - Word-slot counter counts minor cycles modulo ten.
// RULE_17 - Any bus digit with an even count of ones halts at the next hold-off.
package ifs_pkg;

	localparam int DIGIT_W          = 7;
	localparam int WORD_DIGITS      = 12;
	localparam int WORD_W           = DIGIT_W * WORD_DIGITS;
	localparam int INSTR_DIGITS     = 6;
	localparam int INSTR_W          = DIGIT_W * INSTR_DIGITS;
	localparam int CHANNEL_COUNT    = 100;
	localparam logic [3:0] SLOT_LAST   = 4'h9;
	localparam logic [3:0] EXCESS_BIAS = 4'h3;
	localparam logic [3:0] DIGIT_NINE  = 4'h9;

	// Timing of the minor cycle and of the adder path, in sys_clk cycles.
	localparam int MINOR_CYCLE_CLKS_DEFAULT = 84;
	localparam int ADDER_SETTLE_CLKS        = 2;

	// Numeral zero in excess-three with its check bit, and the all-zero word.
	localparam logic [DIGIT_W-1:0] ZERO_DIGIT = 7'h43;
	localparam logic [WORD_W-1:0]  ZERO_WORD  = {WORD_DIGITS{ZERO_DIGIT}};

	// Register map of the plain register port.
	localparam int REG_ADDR_W = 8;
	localparam logic [7:0] OFFSET_CONTROL    = 8'h00;
	localparam logic [7:0] OFFSET_STATUS     = 8'h04;
	localparam logic [7:0] OFFSET_INT_STATUS = 8'h08;
	localparam logic [7:0] OFFSET_INT_MASK   = 8'h0C;
	localparam logic [7:0] OFFSET_ADDRESS    = 8'h10;
	localparam int CONTROL_RUN_BIT        = 0;
	localparam int CONTROL_CLEAR_HALT_BIT = 1;
	localparam int INT_W          = 3;
	localparam int INT_FETCH_BIT  = 0;
	localparam int INT_PARITY_BIT = 1;
	localparam int INT_HALT_BIT   = 2;
	localparam logic [INT_W-1:0] INT_RESET = 3'h0;

	typedef enum logic [1:0] {
		IFS_ALPHA,
		IFS_BETA,
		IFS_GAMMA,
		IFS_DELTA
	} ifs_stage_type;

endpackage : ifs_pkg

// ==== ifs_sequencer.sv ====
// Four-stage instruction fetch sequencer with its register port and interrupt.
//
// Design decisions made here: strobed register access and the placing of the registers.
`timescale 1ns/1ps
module ifs_sequencer
	import ifs_pkg::*;
#(
	parameter int MINOR_CYCLE_CLKS = MINOR_CYCLE_CLKS_DEFAULT
)
(
	input  wire logic                  sys_clk,
	input  wire logic                  reset,
	input  wire logic [REG_ADDR_W-1:0] reg_addr,
	input  wire logic [31:0]           reg_wdata,
	input  wire logic                  reg_write,
	input  wire logic                  reg_read,
	output logic      [31:0]           reg_rdata,
	input  wire logic [WORD_W-1:0]     memory_output_bus,
	input  wire logic                  instr_done,
	output logic      [CHANNEL_COUNT-1:0] channel_select,
	output logic      [CHANNEL_COUNT-1:0] channel_gate_open,
	output logic      [WORD_W-1:0]     distribution_bus,
	output logic      [INSTR_W-1:0]    decode_matrix,
	output logic                       execute_enable,
	output logic      [1:0]            stage_counter,
	output logic                       hold_off_period,
	output logic                       slot_match_flag,
	output logic      [3:0]            word_slot_counter,
	output logic                       minor_cycle_tick,
	output logic                       counter_output_gate,
	output logic                       counter_input_gate,
	output logic                       counter_clear_gate,
	output logic                       holder_input_gate,
	output logic                       holder_clear_gate,
	output logic                       irq
);

	// The settle window must close well before the next minor cycle ends.
	// The divider is sixteen bits wide, which caps the minor cycle length.
	if (MINOR_CYCLE_CLKS < ADDER_SETTLE_CLKS + 2 || MINOR_CYCLE_CLKS > 65536)
	begin : g_bad_cycle
		$error("MINOR_CYCLE_CLKS out of range for the divider or settle window");
	end

	// Decimal value of an excess-three digit.
	function automatic logic [3:0] digit_value(input logic [DIGIT_W-1:0] d);
		digit_value = d[3:0] - EXCESS_BIAS;
	endfunction : digit_value

	// Builds a numeral digit with zone zero and an odd total of ones.
	function automatic logic [DIGIT_W-1:0] make_digit(input logic [3:0] v);
		logic [3:0] bin;
		bin = v + EXCESS_BIAS;
		make_digit = {~(^bin), 2'b00, bin};
	endfunction : make_digit

	// Adds one in digit position twelve, carrying left in decimal.
	function automatic logic [WORD_W-1:0] word_increment(input logic [WORD_W-1:0] w);
		logic       carry;
		logic [3:0] v;
		carry = 1'b1;
		word_increment = w;
		for (int i = 0; i < WORD_DIGITS; i++)
		begin
			v = digit_value(w[i*DIGIT_W +: DIGIT_W]);
			if (carry)
			begin
				if (v == DIGIT_NINE)
				begin
					v = 4'h0;
				end
				else
				begin
					v = v + 4'h1;
					carry = 1'b0;
				end
				word_increment[i*DIGIT_W +: DIGIT_W] = make_digit(v);
			end
		end
	endfunction : word_increment

	// True when any digit of the word carries an even count of ones.
	function automatic logic word_parity_bad(input logic [WORD_W-1:0] w);
		word_parity_bad = 1'b0;
		for (int i = 0; i < WORD_DIGITS; i++)
		begin
			if (!(^w[i*DIGIT_W +: DIGIT_W]))
			begin
				word_parity_bad = 1'b1;
			end
		end
	endfunction : word_parity_bad

	ifs_stage_type           stage_reg;
	logic                    hold_off_flipflop_reg;
	logic [15:0]             tick_count_reg;
	logic [3:0]              word_slot_counter_reg;
	logic [WORD_W-1:0]       instruction_address_counter_reg;
	logic [WORD_W-1:0]       instruction_pair_holder_reg;
	logic [INSTR_W-1:0]      static_instruction_latch_reg;
	logic [WORD_W-1:0]       distribution_bus_reg;
	logic [WORD_W-1:0]       sum_reg;
	logic [1:0]              settle_count_reg;
	logic                    run_reg;
	logic                    halted_reg;
	logic                    parity_pending_reg;
	logic [INT_W-1:0]        int_status_reg;
	logic [INT_W-1:0]        int_status_next;
	logic [INT_W-1:0]        int_mask_reg;
	logic [31:0]             reg_rdata_reg;
	logic [6:0]              channel_index;
	logic                    active;
	logic                    halt_now;
	logic                    alpha_end;
	logic                    beta_end;
	logic                    gamma_end;
	logic                    delta_end;
	logic                    parity_event;
	logic                    clear_halt;

	// The machine moves only on minor cycle boundaries while running and not halted.
	assign active     = minor_cycle_tick && run_reg && !halted_reg;
	assign halt_now   = active && hold_off_flipflop_reg && parity_pending_reg; // [RULE_17]
	assign clear_halt = reg_write && (reg_addr == OFFSET_CONTROL)
		&& reg_wdata[CONTROL_CLEAR_HALT_BIT];

	// Ending pulses of each stage; none fires while hold-off stands.
	assign alpha_end = active && !hold_off_flipflop_reg && (stage_reg == IFS_ALPHA);
	assign beta_end  = active && slot_match_flag; // [RULE_05]
	assign gamma_end = active && execute_enable && instr_done && (stage_reg == IFS_GAMMA);
	assign delta_end = active && execute_enable && instr_done && (stage_reg == IFS_DELTA);

	// Timing unit divider: one tick marks the end of each minor cycle.
	always_ff @(posedge sys_clk or posedge reset)
	begin
		if (reset)
			tick_count_reg <= 16'h0000;
		else if (tick_count_reg == 16'(MINOR_CYCLE_CLKS - 1))
			tick_count_reg <= 16'h0000;
		else
			tick_count_reg <= tick_count_reg + 16'h0001;
	end
	assign minor_cycle_tick = (tick_count_reg == 16'(MINOR_CYCLE_CLKS - 1));

	// Word-slot counter runs freely so it always names the emerging word.
	always_ff @(posedge sys_clk or posedge reset)
	begin
		if (reset)
			word_slot_counter_reg <= 4'h0;
		else if (minor_cycle_tick)
			word_slot_counter_reg <= (word_slot_counter_reg == SLOT_LAST) ? 4'h0 // [RULE_16]
				: word_slot_counter_reg + 4'h1;
	end

	// Stage counter and hold-off flip-flop step together on the ending pulses.
	always_ff @(posedge sys_clk or posedge reset)
	begin
		if (reset)
		begin
			stage_reg             <= IFS_ALPHA;
			hold_off_flipflop_reg <= 1'b1;
		end
		else if (active && hold_off_flipflop_reg && !halt_now)
			hold_off_flipflop_reg <= 1'b0; // [RULE_02] [RULE_12]
		else if (alpha_end)
		begin
			stage_reg             <= IFS_BETA; // [RULE_15]
			hold_off_flipflop_reg <= 1'b1;
		end
		else if (beta_end)
		begin
			stage_reg             <= IFS_GAMMA; // [RULE_08]
			hold_off_flipflop_reg <= 1'b1;
		end
		else if (gamma_end)
		begin
			stage_reg             <= IFS_DELTA; // [RULE_13]
			hold_off_flipflop_reg <= 1'b1;
		end
		else if (delta_end)
		begin
			stage_reg             <= IFS_ALPHA; // [RULE_14]
			hold_off_flipflop_reg <= 1'b1;
		end
	end

	// Slot match is a whole minor cycle wide since both operands hold for the cycle.
	assign slot_match_flag = run_reg && !halted_reg && (stage_reg == IFS_BETA)
		&& !hold_off_flipflop_reg
		&& (word_slot_counter_reg == digit_value(static_instruction_latch_reg[DIGIT_W-1:0])); // [RULE_03]

	// Channel number from the tens and units of the channel pair in the latch.
	assign channel_index = 7'({3'b000, digit_value(static_instruction_latch_reg[20:14])} * 7'd10)
		+ {3'b000, digit_value(static_instruction_latch_reg[13:7])};

	// One select per channel; the index wraps modulo 128, so some non-numeral pairs still select a channel.
	for (genvar g = 0; g < CHANNEL_COUNT; g++)
	begin : g_channel
		assign channel_select[g]    = (channel_index == 7'(g)) && (stage_reg == IFS_BETA); // [RULE_04]
		assign channel_gate_open[g] = channel_select[g] && slot_match_flag; // [RULE_04]
	end

	// Static latch: counter digits in alpha, left half at beta end, right half at gamma end.
	always_ff @(posedge sys_clk or posedge reset)
	begin
		if (reset)
			static_instruction_latch_reg <= ZERO_WORD[INSTR_W-1:0];
		else if (alpha_end)
			static_instruction_latch_reg <= instruction_address_counter_reg[INSTR_W-1:0]; // [RULE_01]
		else if (beta_end)
			static_instruction_latch_reg <= memory_output_bus[WORD_W-1:INSTR_W]; // [RULE_10]
		else if (gamma_end)
			static_instruction_latch_reg <= instruction_pair_holder_reg[INSTR_W-1:0]; // [RULE_13]
	end

	// The holder keeps the pair so the right instruction needs no second access.
	always_ff @(posedge sys_clk or posedge reset)
	begin
		if (reset)
			instruction_pair_holder_reg <= ZERO_WORD;
		else if (beta_end)
			instruction_pair_holder_reg <= memory_output_bus; // [RULE_06] [RULE_11]
		else if (alpha_end)
			instruction_pair_holder_reg <= instruction_address_counter_reg;
	end

	// The sum is held and written only as the settle window closes, after hold-off starts.
	always_ff @(posedge sys_clk or posedge reset)
	begin
		if (reset)
		begin
			sum_reg          <= ZERO_WORD;
			settle_count_reg <= 2'h0;
		end
		else if (beta_end)
		begin
			sum_reg          <= word_increment(instruction_address_counter_reg); // [RULE_07]
			settle_count_reg <= 2'(ADDER_SETTLE_CLKS);
		end
		else if (settle_count_reg != 2'h0)
			settle_count_reg <= settle_count_reg - 2'h1; // [RULE_09]
	end

	// Address counter: software may load it only while the sequencer is stopped.
	always_ff @(posedge sys_clk or posedge reset)
	begin
		if (reset)
			instruction_address_counter_reg <= ZERO_WORD;
		else if (reg_write && (reg_addr == OFFSET_ADDRESS) && !run_reg)
			instruction_address_counter_reg <= {ZERO_WORD[WORD_W-1:3*DIGIT_W],
				make_digit(reg_wdata[11:8]), make_digit(reg_wdata[7:4]),
				make_digit(reg_wdata[3:0])};
		else if (settle_count_reg == 2'h1)
			instruction_address_counter_reg <= sum_reg; // [RULE_07] [RULE_09]
	end

	// Bus is registered so observers see a glitch-free word; the parity check reads the source words directly.
	always_ff @(posedge sys_clk or posedge reset)
	begin
		if (reset)
			distribution_bus_reg <= ZERO_WORD;
		else if (counter_output_gate && (stage_reg == IFS_ALPHA))
			distribution_bus_reg <= instruction_address_counter_reg;
		else if (slot_match_flag)
			distribution_bus_reg <= memory_output_bus; // [RULE_06]
		else
			distribution_bus_reg <= ZERO_WORD;
	end

	// Parity judged on the word each transfer puts on the bus at its ending pulse.
	assign parity_event = (alpha_end && word_parity_bad(instruction_address_counter_reg))
		|| (beta_end && word_parity_bad(memory_output_bus)); // [RULE_17] [RULE_06]

	// A detected error waits for the next hold-off, then freezes the machine there.
	always_ff @(posedge sys_clk or posedge reset)
	begin
		if (reset)
		begin
			parity_pending_reg <= 1'b0;
			halted_reg         <= 1'b0;
		end
		else if (parity_event)
			parity_pending_reg <= 1'b1; // [RULE_17]
		else if (halt_now)
			halted_reg <= 1'b1; // [RULE_17]
		else if (clear_halt)
		begin
			parity_pending_reg <= 1'b0;
			halted_reg         <= 1'b0;
		end
	end

	// Run bit and interrupt mask written by software.
	always_ff @(posedge sys_clk or posedge reset)
	begin
		if (reset)
		begin
			run_reg      <= 1'b0;
			int_mask_reg <= INT_RESET;
		end
		else if (reg_write && (reg_addr == OFFSET_CONTROL))
			run_reg <= reg_wdata[CONTROL_RUN_BIT];
		else if (reg_write && (reg_addr == OFFSET_INT_MASK))
			int_mask_reg <= reg_wdata[INT_W-1:0];
	end

	// Sticky events; a read clears them, but an event in that same cycle survives.
	always_comb
	begin
		int_status_next = int_status_reg;
		if (reg_read && (reg_addr == OFFSET_INT_STATUS))
			int_status_next = INT_RESET;
		int_status_next[INT_FETCH_BIT]  = int_status_next[INT_FETCH_BIT] | beta_end;
		int_status_next[INT_PARITY_BIT] = int_status_next[INT_PARITY_BIT] | parity_event;
		int_status_next[INT_HALT_BIT]   = int_status_next[INT_HALT_BIT] | halt_now;
	end

	always_ff @(posedge sys_clk or posedge reset)
	begin
		if (reset)
			int_status_reg <= INT_RESET;
		else
			int_status_reg <= int_status_next;
	end

	// Read data stand only in the cycle after the strobe; unmapped reads give zero.
	always_ff @(posedge sys_clk or posedge reset)
	begin
		if (reset)
			reg_rdata_reg <= 32'h0000_0000;
		else if (reg_read)
		begin
			unique case (reg_addr)
				OFFSET_CONTROL:
					reg_rdata_reg <= {31'h0000_0000, run_reg};
				OFFSET_STATUS:
					reg_rdata_reg <= {20'h00000, word_slot_counter_reg, 2'b00,
						slot_match_flag, parity_pending_reg, halted_reg,
						hold_off_flipflop_reg, stage_reg};
				OFFSET_INT_STATUS:
					reg_rdata_reg <= {29'h0000_0000, int_status_reg};
				OFFSET_INT_MASK:
					reg_rdata_reg <= {29'h0000_0000, int_mask_reg};
				OFFSET_ADDRESS:
					reg_rdata_reg <= {20'h00000,
						digit_value(instruction_address_counter_reg[20:14]),
						digit_value(instruction_address_counter_reg[13:7]),
						digit_value(instruction_address_counter_reg[6:0])};
				default:
					reg_rdata_reg <= 32'h0000_0000;
			endcase
		end
		else
			reg_rdata_reg <= 32'h0000_0000;
	end

	// Gate controls; hold-off closes the transfer gates and opens the clear paths, the counter ones only once the settle window closes.
	assign counter_output_gate = run_reg && !halted_reg && !hold_off_flipflop_reg
		&& ((stage_reg == IFS_ALPHA) || slot_match_flag); // [RULE_08]
	assign holder_input_gate   = counter_output_gate; // [RULE_06] [RULE_08]
	assign holder_clear_gate   = !holder_input_gate;
	assign counter_input_gate  = slot_match_flag || (settle_count_reg != 2'h0); // [RULE_09]
	assign counter_clear_gate  = !counter_input_gate; // [RULE_08]

	// Decode follows the latch at all times; execution waits for hold-off to drop.
	assign execute_enable = run_reg && !halted_reg && !hold_off_flipflop_reg
		&& ((stage_reg == IFS_GAMMA) || (stage_reg == IFS_DELTA)); // [RULE_12] [RULE_14]
	assign decode_matrix  = static_instruction_latch_reg; // [RULE_12]

	assign distribution_bus  = distribution_bus_reg;
	assign stage_counter     = stage_reg;
	assign hold_off_period   = hold_off_flipflop_reg;
	assign word_slot_counter = word_slot_counter_reg;
	assign reg_rdata         = reg_rdata_reg;
	assign irq               = |(int_status_reg & int_mask_reg);

endmodule : ifs_sequencer

// ==== ifs_sequencer_asserts.sv ====
// Concurrent checks on the port behaviour of the instruction fetch sequencer.
`timescale 1ns/1ps
module ifs_sequencer_chk
	import ifs_pkg::*;
#(
	parameter int MINOR_CYCLE_CLKS = MINOR_CYCLE_CLKS_DEFAULT
)
(
	input wire logic                     sys_clk,
	input wire logic                     reset,
	input wire logic                     instr_done,
	input wire logic [CHANNEL_COUNT-1:0] channel_select,
	input wire logic [CHANNEL_COUNT-1:0] channel_gate_open,
	input wire logic [INSTR_W-1:0]       decode_matrix,
	input wire logic                     execute_enable,
	input wire logic [1:0]               stage_counter,
	input wire logic                     hold_off_period,
	input wire logic                     slot_match_flag,
	input wire logic [3:0]               word_slot_counter,
	input wire logic                     minor_cycle_tick,
	input wire logic                     counter_output_gate,
	input wire logic                     counter_input_gate,
	input wire logic                     counter_clear_gate,
	input wire logic                     holder_input_gate,
	input wire logic                     holder_clear_gate
);
	int tick_gap_reg;

	// Clocks since the last tick, so the tick spacing can be tied to the parameter.
	always_ff @(posedge sys_clk or posedge reset)
	begin
		if (reset)
			tick_gap_reg <= 0;
		else if (minor_cycle_tick)
			tick_gap_reg <= 0;
		else
			tick_gap_reg <= tick_gap_reg + 1;
	end

	default clocking @(posedge sys_clk); endclocking
	default disable iff (reset);

	a_tick_spacing: assert property (minor_cycle_tick |-> tick_gap_reg == MINOR_CYCLE_CLKS - 1)
		else $error("minor cycle tick spacing wrong");
	a_slot_modulo_ten: assert property (minor_cycle_tick |=> word_slot_counter ==
		(($past(word_slot_counter) == SLOT_LAST) ? 4'h0 : $past(word_slot_counter) + 4'h1))
		else $error("word slot counter did not step modulo ten");
	a_stage_in_order: assert property ($changed(stage_counter) |->
		stage_counter == $past(stage_counter) + 2'h1)
		else $error("stage counter left its order");
	a_match_compare: assert property (stage_counter == 2'h1 && !hold_off_period |->
		slot_match_flag == (word_slot_counter == decode_matrix[3:0] - EXCESS_BIAS))
		else $error("slot match flag disagrees with latch digit");
	a_gate_coincide: assert property ($onehot0(channel_select) &&
		channel_gate_open == (channel_select & {CHANNEL_COUNT{slot_match_flag}}))
		else $error("channel gate open without select and match");
	a_hold_suppress: assert property (hold_off_period |-> channel_gate_open == '0 &&
		!execute_enable && !counter_output_gate && !holder_input_gate && holder_clear_gate)
		else $error("transfer during hold-off");
	a_match_gates: assert property (slot_match_flag |-> holder_input_gate &&
		!holder_clear_gate && counter_output_gate && counter_input_gate && !counter_clear_gate)
		else $error("gates wrong in match cycle");
	a_match_ends_beta: assert property (slot_match_flag && minor_cycle_tick |=>
		stage_counter == 2'h2 && hold_off_period)
		else $error("match cycle end did not enter gamma hold-off");
	a_sum_capture: assert property (slot_match_flag && minor_cycle_tick |=>
		counter_input_gate ##1 counter_input_gate ##1 !counter_input_gate && counter_clear_gate)
		else $error("counter input gate timing wrong");
	a_exec_window: assert property (execute_enable |-> stage_counter[1] && !hold_off_period)
		else $error("execution outside gamma or delta run time");
	a_end_pulse_step: assert property (execute_enable && instr_done && minor_cycle_tick |=>
		hold_off_period && stage_counter == $past(stage_counter) + 2'h1)
		else $error("ending pulse did not step the stage");

	c_fetch_done: cover property (slot_match_flag && minor_cycle_tick);
	c_right_instr: cover property (stage_counter == 2'h3 && execute_enable && instr_done && minor_cycle_tick);
	c_slot_wrap: cover property (minor_cycle_tick && word_slot_counter == SLOT_LAST);
endmodule : ifs_sequencer_chk

bind ifs_sequencer ifs_sequencer_chk #(.MINOR_CYCLE_CLKS(MINOR_CYCLE_CLKS)) CHK (.sys_clk, .reset,
	.instr_done, .channel_select, .channel_gate_open, .decode_matrix, .execute_enable,
	.stage_counter, .hold_off_period, .slot_match_flag, .word_slot_counter, .minor_cycle_tick,
	.counter_output_gate, .counter_input_gate, .counter_clear_gate, .holder_input_gate,
	.holder_clear_gate);

// ==== ifs_mem_model.sv ====
// Behavioural delay-line main memory that answers the fetch sequencer.
`timescale 1ns/1ps
module ifs_mem_model
	import ifs_pkg::*;
(
	input  wire logic [0:0]               sys_clk,
	input  wire logic [CHANNEL_COUNT-1:0] channel_gate_open,
	input  wire logic [3:0]               word_slot_counter,
	output logic      [WORD_W-1:0]        memory_output_bus
);
	// Ten words per channel; the testbench fills this array directly.
	logic [WORD_W-1:0] word_mem [0:CHANNEL_COUNT*10-1];
	logic [WORD_W-1:0] bus_reg = ZERO_WORD;

	// Only a gated channel drives; otherwise the line toggles so stale data never looks valid.
	always @(posedge sys_clk)
	begin : drive_bus
		int idx;
		idx = -1;
		for (int c = 0; c < CHANNEL_COUNT; c++)
			if (channel_gate_open[c])
				idx = c * 10 + int'(word_slot_counter);
		bus_reg <= (idx < 0) ? ~bus_reg : word_mem[idx];
	end

	assign memory_output_bus = bus_reg;
endmodule : ifs_mem_model

// ==== tb_top.sv ====
// Self-checking testbench for the instruction fetch sequencer.
`timescale 1ns/1ps
module tb_top
	import ifs_pkg::*;
;
	localparam int MC = 8;
	logic                     sys_clk, reset, reg_write, reg_read, instr_done, irq;
	logic [REG_ADDR_W-1:0]    reg_addr;
	logic [31:0]              reg_wdata, reg_rdata, rd;
	logic [WORD_W-1:0]        memory_output_bus, distribution_bus, word;
	logic [CHANNEL_COUNT-1:0] channel_select, channel_gate_open;
	logic [INSTR_W-1:0]       decode_matrix;
	logic                     execute_enable, hold_off_period, slot_match_flag, minor_cycle_tick;
	logic                     counter_output_gate, counter_input_gate, counter_clear_gate;
	logic                     holder_input_gate, holder_clear_gate;
	logic [1:0]               stage_counter;
	logic [3:0]               word_slot_counter;
	int                       fails, checks, addr;

	ifs_sequencer #(.MINOR_CYCLE_CLKS(MC)) DUT (.sys_clk, .reset, .reg_addr, .reg_wdata,
		.reg_write, .reg_read, .reg_rdata, .memory_output_bus, .instr_done, .channel_select,
		.channel_gate_open, .distribution_bus, .decode_matrix, .execute_enable, .stage_counter,
		.hold_off_period, .slot_match_flag, .word_slot_counter, .minor_cycle_tick,
		.counter_output_gate, .counter_input_gate, .counter_clear_gate, .holder_input_gate,
		.holder_clear_gate, .irq);
	ifs_mem_model MEM (.sys_clk, .channel_gate_open, .word_slot_counter, .memory_output_bus);

	// Free-running system clock.
	initial
	begin
		sys_clk = 1'b0;
		forever #4 sys_clk = ~sys_clk;
	end

	// Random ending pulses so instructions take a varying number of minor cycles.
	always @(posedge sys_clk)
		instr_done <= 1'($urandom_range(0, 1));

	function automatic logic [DIGIT_W-1:0] enc(input int d);
		logic [3:0] b;
		b = 4'(d + 3);
		return {~^b, 2'b00, b};
	endfunction : enc

	function automatic logic [INSTR_W-1:0] latch_of(input int a);
		return {enc(0), enc(0), enc(a / 1000 % 10), enc(a / 100 % 10), enc(a / 10 % 10),
			enc(a % 10)};
	endfunction : latch_of

	function automatic logic [31:0] bcd(input int v);
		return {20'h0, 4'(v / 100), 4'(v / 10 % 10), 4'(v % 10)};
	endfunction : bcd

	function automatic logic [WORD_W-1:0] rand_word();
		logic [WORD_W-1:0] w;
		for (int p = 0; p < WORD_DIGITS; p++)
			w[p*DIGIT_W +: DIGIT_W] = enc($urandom_range(0, 9));
		return w;
	endfunction : rand_word

	task automatic check(input logic [WORD_W-1:0] got, input logic [WORD_W-1:0] exp,
		input string what);
		checks++;
		if (got !== exp)
		begin
			fails++;
			$display("ERROR at %0t: %s got %h expected %h", $time, what, got, exp);
		end
	endtask : check

	task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge sys_clk);
		reg_addr  <= a;
		reg_wdata <= d;
		reg_write <= 1'b1;
		@(posedge sys_clk);
		reg_write <= 1'b0;
	endtask : reg_wr

	task automatic reg_rd(input logic [7:0] a, output logic [31:0] d);
		@(posedge sys_clk);
		reg_addr <= a;
		reg_read <= 1'b1;
		@(posedge sys_clk);
		reg_read <= 1'b0;
		#1 d = reg_rdata;
	endtask : reg_rd

	task automatic wait_stage(input logic [1:0] s);
		int n;
		n = 0;
		while (stage_counter !== s && n < 400)
		begin
			@(posedge sys_clk);
			#1 n++;
		end
		check(n < 400, 1'b1, "stage wait");
	endtask : wait_stage

	// One full four-stage pass on the word at address a.
	task automatic fetch(input int a);
		wait_stage(IFS_BETA);
		check(decode_matrix, latch_of(a), "address latch");
		wait_stage(IFS_GAMMA);
		check(distribution_bus, MEM.word_mem[a % 1000], "bus word");
		check(decode_matrix, MEM.word_mem[a % 1000][WORD_W-1 -: INSTR_W], "left instr");
		check(irq, 1'b0, "masked fetch irq");
		repeat (3) @(posedge sys_clk);
		reg_wr(OFFSET_ADDRESS, 32'h0123);
		reg_rd(OFFSET_ADDRESS, rd);
		check(rd, bcd((a + 1) % 1000), "address step");
		wait_stage(IFS_DELTA);
		check(decode_matrix, MEM.word_mem[a % 1000][INSTR_W-1:0], "right instr");
		wait_stage(IFS_ALPHA);
		check(hold_off_period, 1'b1, "alpha hold-off");
	endtask : fetch

	task automatic stop_test();
		$display("checks %0d fails %0d", checks, fails);
		if (fails == 0 && checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : stop_test

	// Main sequence: reset, two runs of fetches (one wrapping the address), a parity fault.
	initial
	begin
		void'($urandom(47835));
		reset = 1'b1;
		reg_addr = '0;
		reg_wdata = '0;
		reg_write = 1'b0;
		reg_read = 1'b0;
		fails = 0;
		checks = 0;
		repeat (6) @(posedge sys_clk);
		reset <= 1'b0;
		check(stage_counter, IFS_ALPHA, "reset stage");
		check(word_slot_counter, 4'h0, "reset slot");
		reg_rd(OFFSET_STATUS, rd);
		check(rd[3:0], 4'h4, "reset status");
		reg_rd(8'h40, rd);
		check(rd, 32'h0, "unmapped read");
		reg_wr(OFFSET_INT_MASK, 32'h6);
		$display("test reset done");
		for (int r = 0; r < 2; r++)
		begin
			addr = (r == 0) ? 998 : $urandom_range(0, 996);
			for (int k = 0; k < 3; k++)
				MEM.word_mem[(addr + k) % 1000] = rand_word();
			reg_wr(OFFSET_CONTROL, 32'h0);
			reg_wr(OFFSET_ADDRESS, bcd(addr));
			reg_wr(OFFSET_CONTROL, 32'h1);
			for (int k = 0; k < 3; k++)
				fetch(addr + k);
		end
		$display("test fetch done");
		reg_wr(OFFSET_CONTROL, 32'h0);
		addr = $urandom_range(0, 999);
		word = rand_word();
		word[WORD_W-1] = ~word[WORD_W-1];
		MEM.word_mem[addr] = word;
		reg_wr(OFFSET_ADDRESS, bcd(addr));
		reg_rd(OFFSET_INT_STATUS, rd);
		reg_wr(OFFSET_CONTROL, 32'h1);
		wait_stage(IFS_GAMMA);
		repeat (2 * MC + 2) @(posedge sys_clk);
		#1 check(hold_off_period, 1'b1, "halt keeps hold-off");
		check(stage_counter, IFS_GAMMA, "halt freezes stage");
		check(irq, 1'b1, "fault irq");
		reg_rd(OFFSET_INT_STATUS, rd);
		check(rd, 32'h7, "fault status");
		reg_rd(OFFSET_INT_STATUS, rd);
		check(rd, 32'h0, "status cleared");
		check(irq, 1'b0, "irq cleared");
		reg_wr(OFFSET_CONTROL, 32'h3);
		reg_rd(OFFSET_STATUS, rd);
		check(rd[4:3], 2'h0, "halt cleared");
		$display("test parity done");
		stop_test();
	end

	// Watchdog against a hung handshake.
	initial
	begin
		repeat (20000) @(posedge sys_clk);
		fails++;
		stop_test();
	end
endmodule : tb_top
